// ---- inc/iop_pkg.sv ----
// Constants shared by the eight-bit I/O port.
package iop_pkg;
    // Port and bus widths.
    localparam int unsigned PORT_W = 8;
    localparam int unsigned PADDR_W = 17;
    localparam int unsigned PDATA_W = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [14:0] IDX_LAT = 15'h7F50;
    localparam logic [14:0] IDX_IN = 15'h7F51;
    localparam logic [14:0] IDX_DDR = 15'h7F52;
    localparam logic [14:0] IDX_FSA = 15'h7F53;
    localparam logic [14:0] IDX_FSB = 15'h7FF4;
    localparam logic [16:0] ADDR_LAT = {IDX_LAT, 2'b00};
    localparam logic [16:0] ADDR_IN = {IDX_IN, 2'b00};
    localparam logic [16:0] ADDR_DDR = {IDX_DDR, 2'b00};
    localparam logic [16:0] ADDR_FSA = {IDX_FSA, 2'b00};
    localparam logic [16:0] ADDR_FSB = {IDX_FSB, 2'b00};

    // Reset values of the writable registers.
    localparam logic [7:0] RST_LAT = 8'h00;
    localparam logic [7:0] RST_DDR = 8'h00;
    localparam logic [7:0] RST_FSA = 8'h00;
    localparam logic [7:0] RST_FSB = 8'h00;

    // Bits that carry an alternate-function output.
    localparam logic [7:0] ALT_OUT_BITS = 8'hF8;
    localparam int unsigned SERIAL_LSB = 3;
    localparam int unsigned PWM_LSB = 6;
endpackage : iop_pkg

// ---- inc/iop_cfg_if.sv ----
// Configuration and pin-drive bundle between the register file and decoder.
`timescale 1ns/1ns
`default_nettype none
interface iop_cfg_if;
    logic [7:0] lat;
    logic [7:0] ddr;
    logic [7:0] fsa;
    logic [7:0] fsb;
    logic [7:0] drv_o;
    logic [7:0] drv_oe;
    logic [7:0] drv_pu;
    logic [7:0] drv_slow;
    logic [7:0] inv;
    modport reg_side (output lat, ddr, fsa, fsb,
                      input drv_o, drv_oe, drv_pu, drv_slow, inv);
    modport ctl_side (input lat, ddr, fsa, fsb,
                      output drv_o, drv_oe, drv_pu, drv_slow, inv);
endinterface : iop_cfg_if
`default_nettype wire

// ---- rtl/iop_sync.sv ----
// Two-flop synchroniser for the asynchronous pin levels.
`timescale 1ns/1ns
`default_nettype none
module iop_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Raw and synchronised levels.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } iop_sync_s;

    iop_sync_s st_r;
    iop_sync_s st_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // Reset clears both stages so reads are defined from the start.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule : iop_sync
`default_nettype wire

// ---- rtl/iop_pin_ctl.sv ----
// Per-bit decode of latch, direction and function selects into pin drive.
`timescale 1ns/1ns
`default_nettype none
module iop_pin_ctl
    import iop_pkg::*;
#(
    parameter logic [7:0] ALT_MASK = ALT_OUT_BITS
) (
    // Configuration in, drive out.
    iop_cfg_if.ctl_side cfg,
    // Alternate-function output levels, one per bit.
    input wire logic [7:0] alt_out
);
    // Bit 0 level, 1 enable, 2 pull-up, 3 slow edge, 4 read inversion.
    function automatic logic [4:0] decode(input logic fa, input logic fb,
                                          input logic l, input logic d,
                                          input logic has_alt,
                                          input logic a);
        logic o;
        logic oe;
        logic pu;
        logic sl;
        o = 1'b0;
        oe = 1'b0;
        pu = 1'b0;
        sl = 1'b0;
        case ({fa, fb})
            2'b00: begin
                if (d) begin
                    o = l;
                    oe = 1'b1;
                end else begin
                    pu = l;
                end
            end
            2'b01: begin
                if (!d) begin
                    o = l;
                    oe = 1'b1;
                    sl = 1'b1;
                end else begin
                    oe = ~l;
                end
            end
            2'b10: begin
                oe = 1'b1;
                if (!has_alt) begin
                    o = d;
                end else if (l && d) begin
                    o = 1'b1;
                end else if (l) begin
                    o = ~a;
                end else if (d) begin
                    o = a;
                end
            end
            default: begin
                if (!has_alt) begin
                    o = l;
                    oe = ~d;
                    sl = ~d;
                end else if (!d) begin
                    o = l & a;
                    oe = 1'b1;
                    sl = 1'b1;
                end else if (!l) begin
                    oe = ~a; // Open drain: only the low level is driven.
                end
            end
        endcase
        decode = {(~fa & fb & l & d) | (fa & ~fb & l & ~d), sl, pu, oe, o};
    endfunction : decode

    // Decode every bit independently; direction is per bit.
    always_comb begin
        logic [4:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r = decode(cfg.fsa[i], cfg.fsb[i], cfg.lat[i], cfg.ddr[i],
                       ALT_MASK[i], alt_out[i]);
            cfg.drv_o[i] = r[0];
            cfg.drv_oe[i] = r[1];
            cfg.drv_pu[i] = r[2];
            cfg.drv_slow[i] = r[3];
            cfg.inv[i] = r[4];
        end
    end
endmodule : iop_pin_ctl
`default_nettype wire

// ---- rtl/iop_top.sv ----
// Eight-bit I/O port with APB registers, drive decode and pin read path.
// Operation
// - Each of eight pins has its own direction bit; one means output.
// - Eight-bit read-write latch sets output level and plain-input pull-up.
// - Plain input: latch one enables pull-up, latch zero leaves pin floating.
// - Input register read returns sampled levels of all eight pins.
// - Pin read path works under every setting, also while driving.
// - Read value is inverted in the two documented select/latch settings.
// - Pin levels always feed alternate inputs with the same inversion.
// - Bits zero and one always feed the two external interrupt inputs.
// - Bits three to five connect to the second synchronous serial channel.
// - Bits six and seven carry the first pulse-width channel outputs.
// - Plain output: pin driven actively to the latch level.
// - Select B only: slow-edge latch drive as input, low-or-float as output.
// - Bits zero and one: select A forces level; both selects slow or float.
`timescale 1ns/1ns
`default_nettype none
module iop_top
    import iop_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [16:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins.
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pull_en,
    output logic [7:0] pin_slow_en,
    // Alternate functions.
    output logic [7:0] alt_in,
    output logic external_irq_first,
    output logic external_irq_second,
    input wire logic [2:0] sync_serial_channel_one_out,
    input wire logic [1:0] pulse_width_channel_zero_out
);
    typedef struct packed {
        logic [7:0] lat;
        logic [7:0] ddr;
        logic [7:0] fsa;
        logic [7:0] fsb;
        logic [31:0] rdata;
        logic slverr;
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] slow;
        logic [7:0] ain;
    } iop_top_s;

    iop_top_s st_r;
    iop_top_s st_nxt;
    iop_cfg_if cfg ();
    logic [7:0] pin_sync;
    logic [7:0] in_val;
    logic [7:0] alt_out;
    logic setup;
    logic access;

    // Pins come from outside the clock domain.
    iop_sync #(
        .W(PORT_W)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d(pin_i),
        .q(pin_sync)
    );

    // Alternate outputs placed on their bit positions.
    assign alt_out = {pulse_width_channel_zero_out,
                      sync_serial_channel_one_out, 3'h0};

    iop_pin_ctl #(
        .ALT_MASK(ALT_OUT_BITS)
    ) u_ctl (
        .cfg(cfg.ctl_side),
        .alt_out(alt_out)
    );

    // Register values steer the decoder.
    assign cfg.lat = st_r.lat;
    assign cfg.ddr = st_r.ddr;
    assign cfg.fsa = st_r.fsa;
    assign cfg.fsb = st_r.fsb;

    // The read path is never gated, so a driven pin still reads back.
    assign in_val = pin_sync ^ cfg.inv;

    assign setup = psel & ~penable;
    assign access = psel & penable;

    // Is the address one of the five registers.
    function automatic logic mapped(input logic [16:0] a);
        mapped = (a == ADDR_LAT) || (a == ADDR_IN) || (a == ADDR_DDR) ||
                 (a == ADDR_FSA) || (a == ADDR_FSB);
    endfunction : mapped

    // Read data and error are prepared at setup so outputs come from flops.
    // Writes land only at the access edge; zero wait states.
    always_comb begin
        st_nxt = st_r;
        if (setup) begin
            st_nxt.rdata = 32'h0000_0000;
            st_nxt.slverr = ~mapped(paddr) | (pwrite && paddr == ADDR_IN);
            if (!pwrite) begin
                if (paddr == ADDR_LAT) begin
                    st_nxt.rdata[7:0] = st_r.lat;
                end else if (paddr == ADDR_IN) begin
                    st_nxt.rdata[7:0] = in_val;
                end else if (paddr == ADDR_DDR) begin
                    st_nxt.rdata[7:0] = st_r.ddr;
                end else if (paddr == ADDR_FSA) begin
                    st_nxt.rdata[7:0] = st_r.fsa;
                end else if (paddr == ADDR_FSB) begin
                    st_nxt.rdata[7:0] = st_r.fsb;
                end
            end
        end
        if (access && pwrite && pstrb[0]) begin
            if (paddr == ADDR_LAT) begin
                st_nxt.lat = pwdata[7:0];
            end else if (paddr == ADDR_DDR) begin
                st_nxt.ddr = pwdata[7:0];
            end else if (paddr == ADDR_FSA) begin
                st_nxt.fsa = pwdata[7:0];
            end else if (paddr == ADDR_FSB) begin
                st_nxt.fsb = pwdata[7:0];
            end
        end
        // Pin drive is registered; it lags a register write by one cycle.
        st_nxt.o = cfg.drv_o;
        st_nxt.oe = cfg.drv_oe;
        st_nxt.pu = cfg.drv_pu;
        st_nxt.slow = cfg.drv_slow;
        st_nxt.ain = in_val;
    end

    // All state lives in one register.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.lat <= RST_LAT;
            st_r.ddr <= RST_DDR;
            st_r.fsa <= RST_FSA;
            st_r.fsb <= RST_FSB;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs.
    assign prdata = st_r.rdata;
    assign pslverr = st_r.slverr & access;
    assign pready = access;
    assign pin_o = st_r.o;
    assign pin_oe = st_r.oe;
    assign pin_pull_en = st_r.pu;
    assign pin_slow_en = st_r.slow;
    assign alt_in = st_r.ain;
    assign external_irq_first = st_r.ain[0];
    assign external_irq_second = st_r.ain[1];

    // Helper masks over the registered configuration.
    logic [7:0] h_plain_out;
    logic [7:0] h_plain_in;
    logic [7:0] h_slow_in;
    logic [7:0] h_fb_out;
    logic [7:0] h_fa_lo;
    logic [7:0] h_inv;
    logic [1:0] h_pwm_cmos;
    logic wr_lat;
    logic wr_ddr;
    logic rd_in;
    assign h_plain_out = ~st_r.fsa & ~st_r.fsb & st_r.ddr;
    assign h_plain_in = ~st_r.fsa & ~st_r.fsb & ~st_r.ddr;
    assign h_slow_in = ~st_r.fsa & st_r.fsb & ~st_r.ddr;
    assign h_fb_out = ~st_r.fsa & st_r.fsb & st_r.ddr;
    assign h_fa_lo = st_r.fsa & ~st_r.fsb & 8'h03;
    assign h_inv = (~st_r.fsa & st_r.fsb & st_r.lat & st_r.ddr) |
                   (st_r.fsa & ~st_r.fsb & st_r.lat & ~st_r.ddr);
    assign h_pwm_cmos = st_r.fsa[7:6] & ~st_r.fsb[7:6] &
                        ~st_r.lat[7:6] & st_r.ddr[7:6];
    assign wr_lat = access && pwrite && pstrb[0] && paddr == ADDR_LAT;
    assign wr_ddr = access && pwrite && pstrb[0] && paddr == ADDR_DDR;
    assign rd_in = setup && !pwrite && paddr == ADDR_IN;

    direction_write_a: assert property (@(posedge clk) disable iff (reset)
        wr_ddr |=> st_r.ddr == $past(pwdata[7:0]) ##1
        (pin_oe & h_plain_out) == h_plain_out)
        else $error("Direction write did not reach the pin enables.");

    latch_write_a: assert property (@(posedge clk) disable iff (reset)
        wr_lat |=> st_r.lat == $past(pwdata[7:0]))
        else $error("Latch write was not stored.");

    pull_up_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> ((pin_pull_en ^ $past(st_r.lat)) & $past(h_plain_in)) == 0 &&
        (pin_oe & $past(h_plain_in)) == 0)
        else $error("Plain input pull-up or float is wrong.");

    input_read_a: assert property (@(posedge clk) disable iff (reset)
        rd_in |=> prdata == {24'h000000, $past(in_val)} && pready)
        else $error("Input register read returned a wrong value.");

    read_invert_a: assert property (@(posedge clk) disable iff (reset)
        ((in_val ^ pin_sync) == h_inv))
        else $error("Read inversion does not match the settings.");

    alt_input_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> alt_in == ($past(pin_sync) ^ $past(h_inv)))
        else $error("Alternate input does not follow the pin.");

    irq_route_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> {external_irq_second, external_irq_first} ==
        ($past(pin_sync[1:0]) ^ $past(h_inv[1:0])))
        else $error("Interrupt inputs do not follow bits zero and one.");

    pwm_drive_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> ((pin_o[7:6] ^ $past(pulse_width_channel_zero_out)) &
        $past(h_pwm_cmos)) == 2'b00)
        else $error("Pulse-width output not on bits six and seven.");

    plain_drive_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> ((pin_o ^ $past(st_r.lat)) & $past(h_plain_out)) == 0 &&
        (pin_oe & $past(h_plain_out)) == $past(h_plain_out))
        else $error("Plain output not driven to the latch.");

    slow_drive_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> (pin_slow_en & $past(h_slow_in)) == $past(h_slow_in) &&
        ((pin_oe ^ ~$past(st_r.lat)) & $past(h_fb_out)) == 0)
        else $error("Select B drive style is wrong.");

    force_level_a: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> ((pin_o ^ $past(st_r.ddr)) & $past(h_fa_lo)) == 0 &&
        (pin_oe & $past(h_fa_lo)) == $past(h_fa_lo))
        else $error("Bits zero and one forced level is wrong.");

    unmapped_err_a: assert property (@(posedge clk) disable iff (reset)
        setup && !mapped(paddr) ##1 access |-> pslverr && prdata == 0)
        else $error("Unmapped access not flagged.");
endmodule : iop_top
`default_nettype wire

// ---- verification/iop_pin_model.sv ----
// Model of the circuitry outside the port pins: resolves each pin level.
`timescale 1ns/1ns
`default_nettype none
module iop_pin_model (
    // Clock.
    input wire logic clk,
    // Drive from the port.
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull_en,
    // Drive from the outside world.
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Resolved pin levels.
    output logic [7:0] pin_lvl
);
    // A known start keeps floating pins defined; unknowns would stick forever.
    logic [7:0] last_r = 8'h00;

    // The port wins over the outside; a pin nobody drives or pulls flips
    // every cycle, so a reading of a floating pin can never look stable.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_lvl[i] = pin_o[i];
            end else if (ext_en[i]) begin
                pin_lvl[i] = ext_val[i];
            end else if (pin_pull_en[i]) begin
                pin_lvl[i] = 1'b1;
            end else begin
                pin_lvl[i] = ~last_r[i];
            end
        end
    end

    // Remember the last level for the floating case.
    always_ff @(posedge clk) begin
        last_r <= pin_lvl;
    end
endmodule : iop_pin_model
`default_nettype wire

// ---- verification/tb_eight_bit_io_port_four.sv ----
// Self-checking testbench of the eight-bit I/O port.
`timescale 1ns/1ns
`default_nettype none
module tb_eight_bit_io_port_four
    import iop_pkg::*;
;
    logic clk;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [16:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_lvl;
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic [7:0] pin_pull_en;
    logic [7:0] pin_slow_en;
    logic [7:0] alt_in;
    logic [7:0] ext_val;
    logic [7:0] ext_en;
    logic irq_a;
    logic irq_b;
    logic [2:0] ser_out;
    logic [1:0] pwm_out;
    logic [7:0] rdat;
    logic rerr;
    int err_total;
    int compares;

    iop_top DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pull_en(pin_pull_en), .pin_slow_en(pin_slow_en),
        .alt_in(alt_in), .external_irq_first(irq_a),
        .external_irq_second(irq_b), .sync_serial_channel_one_out(ser_out),
        .pulse_width_channel_zero_out(pwm_out));

    iop_pin_model partner (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pull_en(pin_pull_en), .ext_val(ext_val), .ext_en(ext_en),
        .pin_lvl(pin_lvl));

    // Clock and time-zero values of every input.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reset, psel, penable, pwrite} = 4'b1000;
        paddr = 17'h00000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        ext_val = 8'h00;
        ext_en = 8'h00;
        ser_out = 3'h0;
        pwm_out = 2'h0;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, so only the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [16:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [16:0] a, input logic [7:0] exp,
                      input logic eexp);
        apb(1'b0, a, 8'h00);
        chk(rdat, exp);
        chk({7'h00, rerr}, {7'h00, eexp});
    endtask : rd

    // Writes all four settings, then waits past the pin synchroniser.
    task automatic set(input logic [7:0] fa, input logic [7:0] fb,
                       input logic [7:0] lt, input logic [7:0] dr);
        apb(1'b1, ADDR_FSA, fa);
        apb(1'b1, ADDR_FSB, fb);
        apb(1'b1, ADDR_LAT, lt);
        apb(1'b1, ADDR_DDR, dr);
        repeat (6) @(posedge clk);
        #1;
    endtask : set

    task automatic t_reset;
        rd(ADDR_LAT, RST_LAT, 1'b0);
        rd(ADDR_DDR, RST_DDR, 1'b0);
        rd(ADDR_FSA, RST_FSA, 1'b0);
        rd(ADDR_FSB, RST_FSB, 1'b0);
        chk(pin_oe | pin_pull_en, 8'h00);
        rd(17'h00000, 8'h00, 1'b1);
        apb(1'b1, ADDR_IN, 8'hFF);
        chk({7'h00, rerr}, 8'h01);
        @(posedge clk);
        pstrb <= 4'h0;
        apb(1'b1, ADDR_LAT, 8'hFF);
        pstrb <= 4'hF;
        rd(ADDR_LAT, 8'h00, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_plain;
        ext_en <= 8'hC3;
        ext_val <= 8'h81;
        set(8'h00, 8'h00, 8'hA5, 8'h3C);
        chk(pin_oe, 8'h3C);
        chk(pin_o & 8'h3C, 8'h24);
        chk(pin_pull_en, 8'h81);
        rd(ADDR_IN, 8'hA5, 1'b0);
        rd(ADDR_LAT, 8'hA5, 1'b0);
        $display("test plain done");
    endtask : t_plain

    task automatic t_selb;
        ext_en <= 8'h00;
        set(8'h00, 8'hFF, 8'h0F, 8'hF0);
        chk(pin_oe, 8'hFF);
        chk(pin_o, 8'h0F);
        chk(pin_slow_en & 8'h0F, 8'h0F);
        ext_en <= 8'hFF;
        ext_val <= 8'h5A;
        set(8'h00, 8'hFF, 8'hFF, 8'hFF);
        chk(pin_oe, 8'h00);
        rd(ADDR_IN, 8'hA5, 1'b0);
        chk(alt_in, 8'hA5);
        chk({6'h00, irq_b, irq_a}, 8'h01);
        $display("test select b done");
    endtask : t_selb

    task automatic t_sela;
        ext_en <= 8'hFC;
        ext_val <= 8'h00;
        set(8'h03, 8'h00, 8'h03, 8'h00);
        chk({pin_oe[1:0], pin_o[1:0]}, 8'h0C);
        rd(ADDR_IN, 8'h03, 1'b0);
        chk({6'h00, irq_b, irq_a}, 8'h03);
        set(8'h03, 8'h00, 8'h00, 8'h03);
        chk({pin_oe[1:0], pin_o[1:0]}, 8'h0F);
        rd(ADDR_IN, 8'h03, 1'b0);
        set(8'h03, 8'h03, 8'h02, 8'h00);
        chk({pin_oe[1:0], pin_o[1:0]}, 8'h0E);
        chk({6'h00, pin_slow_en[1:0]}, 8'h03);
        set(8'h03, 8'h03, 8'h02, 8'h03);
        chk({6'h00, pin_oe[1:0]}, 8'h00);
        $display("test select a done");
    endtask : t_sela

    task automatic t_alt;
        ser_out <= 3'h5;
        pwm_out <= 2'h2;
        set(8'hF8, 8'h00, 8'h00, 8'hF8);
        chk(pin_oe & 8'hF8, 8'hF8);
        chk(pin_o & 8'hF8, 8'hA8);
        @(posedge clk);
        ser_out <= 3'h2;
        pwm_out <= 2'h1;
        repeat (6) @(posedge clk);
        #1;
        chk(pin_o & 8'hF8, 8'h50);
        chk(alt_in & 8'hF8, 8'h50);
        // Both selects: slow alternate drive on inputs, open drain on outputs.
        set(8'hF8, 8'hF8, 8'h18, 8'h60);
        chk(pin_oe & 8'hF8, 8'hB8);
        chk(pin_o & 8'hF8, 8'h10);
        chk(pin_slow_en & 8'hF8, 8'h98);
        // Select A with latch one inverts both the drive and the read.
        set(8'hF8, 8'h00, 8'hF8, 8'h00);
        chk(pin_o & 8'hF8, 8'hA8);
        chk(alt_in & 8'hF8, 8'h50);
        $display("test alternate done");
    endtask : t_alt

    task automatic stop_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // The whole run needs about two hundred and fifty cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_plain();
        t_selb();
        t_sela();
        t_alt();
        stop_test();
    end
endmodule : tb_eight_bit_io_port_four
`default_nettype wire
